/* hdl/multi_mode_timer_unit.sv */
// Purpose: Four-subsystem PWM / capture timer unit behind an APB slave
// Assumes: Single clock, synchronous reset, pins sampled through two flops
// Notes:   Zero-wait APB: pready answers in the cycle after setup
//          Interrupt sources per subsystem: A ch0 period/capture0,
//          B ch1 period/capture1, C ch0 duty/capture overflow, D ch1 duty

// Summary of operation
// - Four subsystems run fully independent
// - Modes: dual 8-bit PWM, 16-bit PWM, capture
// - Own 8-bit prescaler divides the clock
// - 16-bit up-counter plus two 16-bit registers
// - Low power mode stops only that subsystem's clock
// - Mode decides pins are outputs or inputs
// - Software chooses PWM output polarity per pin
// - Capture edges and counter reset selectable
// - Four interrupt requests, one per subsystem
// - Sixteen sources, each pending and enable bit
// - Clear after period, invert at 0-1, revert after duty
// - Duty above a nonzero period 100%, duty zero 0%
// - Period and duty double buffered in PWM
// - Capture copies counter to period or duty
module multi_mode_timer_unit #(
  parameter int NUM_SUB = 4
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_ce,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [7:0]             i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  input  wire logic [2*NUM_SUB-1:0]   i_timer_io_pin,
  output logic      [2*NUM_SUB-1:0]   o_timer_io_pin,
  output logic      [2*NUM_SUB-1:0]   o_timer_io_pin_oe,
  output logic      [NUM_SUB-1:0]     o_irq
);
  localparam int SW = mmtu_pkg::SRC_PER_SUB * NUM_SUB;

  typedef struct packed {
    mmtu_pkg::sub_type [NUM_SUB-1:0] sub;
    logic [SW-1:0]                   stat;
    logic [SW-1:0]                   mask;
    logic [NUM_SUB-1:0]              irq;
    logic [2*NUM_SUB-1:0]            tio;
    logic [2*NUM_SUB-1:0]            oe;
    logic [31:0]                     rdata;
    logic                            ready;
    logic                            err;
  } state_type;

  state_type           q, d;
  logic [2*NUM_SUB-1:0] pin_rise;
  logic [2*NUM_SUB-1:0] pin_fall;
  mmtu_pkg::sub_type   s;
  mmtu_pkg::sel_type   sel_r;
  mmtu_pkg::sel_type   sel_w;
  logic [18:0]         res;
  logic [1:0]          en;
  logic [1:0]          ev;
  logic [3:0]          src;
  logic                tick;
  logic                wr;
  logic [SW-1:0]       stat_set;
  logic [SW-1:0]       lp_lock;
  logic [1:0]          sidx;

  if (NUM_SUB < 1 || NUM_SUB > mmtu_pkg::SUB_MAX) begin : g_chk
    $error("NUM_SUB must be 1 to 4");
  end

  // Address decode shared by read setup and write access
  function automatic mmtu_pkg::sel_type decode(input logic [7:0] a);
    if (a == mmtu_pkg::ADDR_STAT) begin
      return mmtu_pkg::SEL_STAT;
    end else if (a == mmtu_pkg::ADDR_MASK) begin
      return mmtu_pkg::SEL_MASK;
    end else if (a[7] || int'(a[6:5]) >= NUM_SUB) begin
      return mmtu_pkg::SEL_NONE;
    end else if (a[4:0] == mmtu_pkg::OFF_CTRL) begin
      return mmtu_pkg::SEL_CTRL;
    end else if (a[4:0] == mmtu_pkg::OFF_PRESC) begin
      return mmtu_pkg::SEL_PRESC;
    end else if (a[4:0] == mmtu_pkg::OFF_CNT) begin
      return mmtu_pkg::SEL_CNT;
    end else if (a[4:0] == mmtu_pkg::OFF_PER) begin
      return mmtu_pkg::SEL_PER;
    end else if (a[4:0] == mmtu_pkg::OFF_DTY) begin
      return mmtu_pkg::SEL_DTY;
    end else begin
      return mmtu_pkg::SEL_NONE;
    end
  endfunction

  // One counter increment: {duty hit, period hit, new inversion, new count}
  function automatic logic [18:0] pwm_step(input logic [15:0] c, input logic [15:0] p,
                                           input logic [15:0] dt, input logic [15:0] msk,
                                           input logic inv);
    logic [15:0] nc;
    logic        ni;
    nc = (c == p) ? mmtu_pkg::CNT_RST : ((c + 16'h0001) & msk);
    ni = inv;
    if (c == dt) begin
      ni = 1'b0;
    end else if (c == 16'h0000 && nc == 16'h0001) begin
      ni = 1'b1;
    end
    return {(c == dt), (c == p), ni, nc};
  endfunction

  // Pin synchronisers and edge detection
  mmtu_pin_sync #(
    .WIDTH (2*NUM_SUB)
  ) u_sync (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_pin  (i_timer_io_pin),
    .o_rise (pin_rise),
    .o_fall (pin_fall)
  );

  // Next-state logic: bus, subsystems, interrupts
  always_comb begin
    d        = q;
    s        = '0;
    res      = '0;
    en       = '0;
    ev       = '0;
    src      = '0;
    tick     = 1'b0;
    stat_set = '0;
    lp_lock  = '0;
    sidx     = i_paddr[6:5];
    sel_r    = decode(i_paddr);
    sel_w    = sel_r;
    wr       = i_psel && i_penable && q.ready && i_pwrite;
    // APB setup phase: answer prepared for access phase
    d.ready  = i_psel && !i_penable;
    if (i_psel && !i_penable) begin
      d.err   = (sel_r == mmtu_pkg::SEL_NONE);
      d.rdata = mmtu_pkg::RDATA_NONE;
      if (sel_r == mmtu_pkg::SEL_STAT) begin
        d.rdata[SW-1:0] = q.stat;
      end else if (sel_r == mmtu_pkg::SEL_MASK) begin
        d.rdata[SW-1:0] = q.mask;
      end else if (sel_r != mmtu_pkg::SEL_NONE) begin
        s = q.sub[sidx];
        case (sel_r)
          mmtu_pkg::SEL_CTRL:  d.rdata[11:0] = {s.output_polarity, s.crst, s.edg,
                                                s.channel_run, s.mode};
          mmtu_pkg::SEL_PRESC: d.rdata[7:0]  = s.prescale_value;
          mmtu_pkg::SEL_CNT:   d.rdata[15:0] = s.subsystem_counter;
          mmtu_pkg::SEL_PER:   d.rdata[15:0] = s.period_capture_reg;
          mmtu_pkg::SEL_DTY:   d.rdata[15:0] = s.duty_capture_reg;
          default:             d.rdata       = mmtu_pkg::RDATA_NONE;
        endcase
      end
    end
    if (wr && sel_w == mmtu_pkg::SEL_MASK) begin
      d.mask = i_pwdata[SW-1:0];
    end
    // Each subsystem evolves from its own state only
    for (int n = 0; n < NUM_SUB; n++) begin
      s      = q.sub[n];
      src    = '0;
      en[0]  = s.channel_run[0];
      en[1]  = s.channel_run[1] && (s.mode == mmtu_pkg::MODE_DUAL8);
      tick   = (en != 2'b00) && (s.psc == s.prescale_value);
      for (int c = 0; c < 2; c++) begin
        ev[c] = s.channel_run[0] && (s.mode == mmtu_pkg::MODE_CAPT)
                && ((pin_rise[2*n+c] && s.edg[2*c+mmtu_pkg::EDG_RISE])
                 || (pin_fall[2*n+c] && s.edg[2*c+mmtu_pkg::EDG_FALL]));
      end
      if (s.mode != mmtu_pkg::MODE_LOWPWR) begin
        s.psc = (en == 2'b00 || tick) ? mmtu_pkg::PRESC_RST : s.psc + 8'h01;
        case (s.mode)
          mmtu_pkg::MODE_DUAL8: begin
            for (int c = 0; c < 2; c++) begin
              if (!en[c]) begin
                s.inv[c] = 1'b0;
                s.per_act[8*c +: 8] = s.period_capture_reg[8*c +: 8];
                s.dty_act[8*c +: 8] = s.duty_capture_reg[8*c +: 8];
              end else if (tick) begin
                res = pwm_step({8'h00, s.subsystem_counter[8*c +: 8]},
                               {8'h00, s.per_act[8*c +: 8]},
                               {8'h00, s.dty_act[8*c +: 8]}, mmtu_pkg::MASK8, s.inv[c]);
                s.subsystem_counter[8*c +: 8] = res[7:0];
                s.inv[c]   = res[16];
                src[c]     = res[17];
                src[2+c]   = res[18];
                if (res[17]) begin
                  s.per_act[8*c +: 8] = s.period_capture_reg[8*c +: 8];
                  s.dty_act[8*c +: 8] = s.duty_capture_reg[8*c +: 8];
                end
              end
            end
          end
          mmtu_pkg::MODE_PWM16: begin
            if (!en[0]) begin
              s.inv     = 2'b00;
              s.per_act = s.period_capture_reg;
              s.dty_act = s.duty_capture_reg;
            end else if (tick) begin
              res = pwm_step(s.subsystem_counter, s.per_act, s.dty_act,
                             mmtu_pkg::MASK16, s.inv[0]);
              s.subsystem_counter = res[15:0];
              s.inv    = {2{res[16]}};
              src[0]   = res[17];
              src[2]   = res[18];
              if (res[17]) begin
                s.per_act = s.period_capture_reg;
                s.dty_act = s.duty_capture_reg;
              end
            end
          end
          mmtu_pkg::MODE_CAPT: begin
            s.inv = 2'b00;
            if (tick) begin
              src[2] = (s.subsystem_counter == mmtu_pkg::MASK16);
              s.subsystem_counter = s.subsystem_counter + 16'h0001;
            end
            if (ev[0]) begin
              s.period_capture_reg = q.sub[n].subsystem_counter;
              s.per_act = q.sub[n].subsystem_counter;
            end
            if (ev[1]) begin
              s.duty_capture_reg = q.sub[n].subsystem_counter;
              s.dty_act = q.sub[n].subsystem_counter;
            end
            src[1:0] = ev;
            if ((ev & s.crst) != 2'b00) begin
              s.subsystem_counter = mmtu_pkg::CNT_RST;
              s.psc = mmtu_pkg::PRESC_RST;
            end
          end
          default: begin
            s.inv = 2'b00;
          end
        endcase
      end else begin
        lp_lock[4*n +: 4] = 4'hF;
      end
      // Register writes land after the timing step
      if (wr && int'(sidx) == n) begin
        if (sel_w == mmtu_pkg::SEL_CTRL) begin
          s.mode            = mmtu_pkg::mode_type'(i_pwdata[mmtu_pkg::CTRL_MODE_LSB +: 2]);
          s.channel_run     = i_pwdata[mmtu_pkg::CTRL_RUN_LSB +: 2];
          s.edg             = i_pwdata[mmtu_pkg::CTRL_EDG_LSB +: 4];
          s.crst            = i_pwdata[mmtu_pkg::CTRL_CRST_LSB +: 2];
          s.output_polarity = i_pwdata[mmtu_pkg::CTRL_POL_LSB +: 2];
        end else if (sel_w == mmtu_pkg::SEL_PRESC) begin
          s.prescale_value = i_pwdata[7:0];
        end else if (q.sub[n].mode != mmtu_pkg::MODE_LOWPWR) begin
          if (sel_w == mmtu_pkg::SEL_CNT && q.sub[n].channel_run == 2'b00) begin
            s.subsystem_counter = i_pwdata[15:0];
          end else if (sel_w == mmtu_pkg::SEL_PER) begin
            s.period_capture_reg = i_pwdata[15:0];
          end else if (sel_w == mmtu_pkg::SEL_DTY) begin
            s.duty_capture_reg = i_pwdata[15:0];
          end
        end
      end
      d.sub[n] = s;
      stat_set[4*n +: 4] = src;
      // Pin direction and PWM level
      d.oe[2*n +: 2]  = {2{s.mode == mmtu_pkg::MODE_DUAL8 || s.mode == mmtu_pkg::MODE_PWM16}};
      d.tio[2*n +: 2] = d.oe[2*n +: 2] & (s.output_polarity ^ s.inv);
    end
    // Sticky flags: set wins, low power blocks clearing
    if (wr && sel_w == mmtu_pkg::SEL_STAT) begin
      d.stat = (q.stat & ~(i_pwdata[SW-1:0] & ~lp_lock)) | stat_set;
    end else begin
      d.stat = q.stat | stat_set;
    end
    for (int n = 0; n < NUM_SUB; n++) begin
      d.irq[n] = |(d.stat[4*n +: 4] & d.mask[4*n +: 4]);
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign o_prdata          = q.rdata;
  assign o_pready          = q.ready;
  assign o_pslverr         = q.err;
  assign o_timer_io_pin    = q.tio;
  assign o_timer_io_pin_oe = q.oe;
  assign o_irq             = q.irq;

  // Checks on subsystem 0
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  irq_level_a: assert property (o_irq[0] == |(q.stat[3:0] & q.mask[3:0]))
    else $error("irq does not follow enabled pending flags");
  lp_freeze_a: assert property ((i_ce && q.sub[0].mode == mmtu_pkg::MODE_LOWPWR)
    |=> $stable(q.sub[0].subsystem_counter) && $stable(q.sub[0].psc))
    else $error("counter moved in low power");
  presc_gate_a: assert property ((i_ce && q.sub[0].mode == mmtu_pkg::MODE_PWM16
    && q.sub[0].channel_run[0] && q.sub[0].psc != q.sub[0].prescale_value)
    |=> $stable(q.sub[0].subsystem_counter))
    else $error("counter moved without prescaler match");
  period_wrap_a: assert property ((i_ce && q.sub[0].mode == mmtu_pkg::MODE_PWM16
    && q.sub[0].channel_run[0] && q.sub[0].psc == q.sub[0].prescale_value
    && q.sub[0].subsystem_counter == q.sub[0].per_act)
    |=> q.sub[0].subsystem_counter == 16'h0000)
    else $error("counter not cleared after period");
  pol_idle_a: assert property ((q.sub[0].mode == mmtu_pkg::MODE_PWM16 && !q.sub[0].inv[0])
    |-> o_timer_io_pin[0] == q.sub[0].output_polarity[0] && o_timer_io_pin_oe[0])
    else $error("idle pwm pin not at polarity default");
  zero_duty_a: assert property ((i_ce && q.sub[0].mode == mmtu_pkg::MODE_PWM16
    && q.sub[0].channel_run[0] && q.sub[0].psc == q.sub[0].prescale_value
    && q.sub[0].dty_act == 16'h0000) |=> !q.sub[0].inv[0])
    else $error("zero duty inverted the output");
  full_duty_a: assert property ((i_ce && q.sub[0].mode == mmtu_pkg::MODE_PWM16
    && q.sub[0].channel_run[0] && q.sub[0].psc == q.sub[0].prescale_value
    && q.sub[0].subsystem_counter == 16'h0000 && q.sub[0].per_act != 16'h0000
    && q.sub[0].dty_act > q.sub[0].per_act) |=> q.sub[0].inv[0])
    else $error("output not inverted at 0 to 1 step");
  buf_hold_a: assert property ((i_ce && q.sub[0].mode == mmtu_pkg::MODE_PWM16
    && q.sub[0].channel_run[0] && !(q.sub[0].psc == q.sub[0].prescale_value
    && q.sub[0].subsystem_counter == q.sub[0].per_act)) |=> $stable(q.sub[0].per_act))
    else $error("active period changed before match");
  capt_copy_a: assert property ((i_ce && !i_psel && q.sub[0].mode == mmtu_pkg::MODE_CAPT
    && q.sub[0].channel_run[0] && pin_rise[0] && q.sub[0].edg[0])
    |=> q.sub[0].period_capture_reg == $past(q.sub[0].subsystem_counter))
    else $error("capture did not copy counter");

  capt_event_c: cover property (q.sub[0].mode == mmtu_pkg::MODE_CAPT && pin_rise[0]);
  irq_raise_c: cover property ($rose(o_irq[0]));
  pwm_toggle_c: cover property (o_timer_io_pin_oe[0] ##1 $changed(o_timer_io_pin[0]));
endmodule

/* common/mmtu_pkg.sv */
// Purpose: Shared constants and types of the multi-mode timer unit
// Assumes: APB slave with 32-bit data, 8-bit byte address
// Notes:   Each subsystem owns a 32-byte window; status and mask sit above them
package mmtu_pkg;
  // Address map
  localparam int         ADDR_W        = 8;
  localparam int         SUB_MAX       = 4;
  localparam logic [4:0] OFF_CTRL      = 5'h00;
  localparam logic [4:0] OFF_PRESC     = 5'h04;
  localparam logic [4:0] OFF_CNT       = 5'h08;
  localparam logic [4:0] OFF_PER       = 5'h0C;
  localparam logic [4:0] OFF_DTY       = 5'h10;
  localparam logic [7:0] ADDR_STAT     = 8'h80;
  localparam logic [7:0] ADDR_MASK     = 8'h84;
  // Control register fields
  localparam int         CTRL_MODE_LSB = 0;
  localparam int         CTRL_RUN_LSB  = 2;
  localparam int         CTRL_EDG_LSB  = 4;
  localparam int         CTRL_CRST_LSB = 8;
  localparam int         CTRL_POL_LSB  = 10;
  // Capture edge select bits per pin
  localparam int         EDG_RISE      = 0;
  localparam int         EDG_FALL      = 1;
  // Interrupt sources per subsystem
  localparam int         SRC_PER_SUB   = 4;
  // Widths, masks and reset values
  localparam int         LANE_W        = 8;
  localparam logic [15:0] MASK8        = 16'h00FF;
  localparam logic [15:0] MASK16       = 16'hFFFF;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [7:0]  PRESC_RST    = 8'h00;
  localparam logic [31:0] RDATA_NONE   = 32'h0000_0000;

  typedef enum logic [1:0] {MODE_LOWPWR, MODE_DUAL8, MODE_PWM16, MODE_CAPT} mode_type;
  typedef enum logic [2:0] {SEL_NONE, SEL_CTRL, SEL_PRESC, SEL_CNT, SEL_PER, SEL_DTY,
                            SEL_STAT, SEL_MASK} sel_type;

  // State of one timer subsystem
  typedef struct packed {
    mode_type    mode;
    logic [1:0]  channel_run;
    logic [3:0]  edg;
    logic [1:0]  crst;
    logic [1:0]  output_polarity;
    logic [7:0]  prescale_value;
    logic [7:0]  psc;
    logic [15:0] subsystem_counter;
    logic [15:0] period_capture_reg;
    logic [15:0] duty_capture_reg;
    logic [15:0] per_act;
    logic [15:0] dty_act;
    logic [1:0]  inv;
  } sub_type;
endpackage

/* hdl/mmtu_pin_sync.sv */
// Purpose: Two-stage synchroniser and edge detector for timer pins
// Assumes: Pins are asynchronous to i_clk
// Notes:   Edge outputs are combinational from the synchronised stages
module mmtu_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_rise,
  output logic      [WIDTH-1:0] o_fall
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } sync_type;

  sync_type q, d;

  if (WIDTH < 1) begin : g_chk
    $error("mmtu_pin_sync needs at least one pin");
  end

  // Shift chain, first stage read only by second
  always_comb begin
    d      = q;
    d.meta = i_pin;
    d.sync = q.meta;
    d.prev = q.sync;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // Edges between the second and third stage
  assign o_rise = q.sync & ~q.prev;
  assign o_fall = ~q.sync & q.prev;
endmodule

/* tb/mmtu_pin_model.sv */
// Purpose: External pin partner for the timer unit
// Assumes: Driven at rising edges, one clock domain
// Notes:   Resolves each pin from the design enable and the model level
module mmtu_pin_model #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe,
  output logic      [W-1:0] o_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] drv_q = '0;
  // Design drives while enabled, model drives otherwise
  assign o_wire = (i_oe & i_out) | (~i_oe & drv_q);
  // Raise the masked lines for width cycles, then drop them
  task automatic pulse(input logic [W-1:0] m, input int width);
    @(posedge i_clk);
    drv_q <= drv_q | m;
    repeat (width) @(posedge i_clk);
    drv_q <= drv_q & ~m;
  endtask
endmodule

/* tb/multi_mode_timer_unit_tb_top.sv */
// Purpose: Self-checking bench of the timer unit over APB and pins
// Assumes: Zero-wait APB slave, four subsystems
// Notes:   Expected pin duty counts come from integer period arithmetic
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch at %0t: got %0h exp %0h", $time, a, b); end end
module multi_mode_timer_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 0, i_rst = 1, psel = 0, penable = 0, pwrite = 0, ce = 1;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, er;
  logic [7:0]  pin_out, pin_oe, pin_wire;
  logic [3:0]  irq;
  int          n_errors = 0, cmp_count = 0, seed = 32'hb9bd, h0, h1, w, per, dty, p, pw;
  multi_mode_timer_unit multi_mode_timer_unit_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_timer_io_pin(pin_wire),
    .o_timer_io_pin(pin_out), .o_timer_io_pin_oe(pin_oe), .o_irq(irq));
  mmtu_pin_model mmtu_pin_model_i (
    .i_clk(i_clk), .i_out(pin_out), .i_oe(pin_oe), .o_wire(pin_wire));
  // Clock of 10 ns period
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // Verdict and end of run
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge i_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d, rd, er);
  endtask
  // High cycles of one pin over n samples
  task automatic measure(input int pin, input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge i_clk);
      #1 hi += (pin_out[pin] === 1'b1);
    end
  endtask
  // Integer model of high cycles over k periods with polarity 0
  function automatic int model_hi(int pr, int dt, int ps, int k);
    if (dt == 0) return 0;
    if (dt > pr) return k * (pr + 1) * (ps + 1);
    return k * dt * (ps + 1);
  endfunction
  // Subsystem 0 in 16-bit PWM, pin 1 with inverted polarity
  task automatic pwm16_case(input int pr, input int dt, input int ps);
    pw = (pr + 1) * (ps + 1);
    wr(8'h00, 32'h0000_0002);
    wr(8'h04, ps);
    wr(8'h0C, pr);
    wr(8'h10, dt);
    wr(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0000_0806);
    repeat (2 * pw) @(posedge i_clk);
    measure(0, 4 * pw, h0);
    `CHK(h0, model_hi(pr, dt, ps, 4))
    measure(1, 4 * pw, h1);
    `CHK(h1, 4 * pw - model_hi(pr, dt, ps, 4))
    `CHK(pin_oe[1:0], 2'b11)
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 0;
    // Reset values and unmapped access
    apb(0, 8'h00, 0, rd, er);
    `CHK(rd, 32'h0000_0000)
    apb(0, 8'h84, 0, rd, er);
    `CHK(rd, 32'h0000_0000)
    apb(0, 8'h90, 0, rd, er);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    // Duty zero, duty above period, random duty inside
    for (int c = 0; c < 3; c++) begin
      per = 2 + $unsigned($random(seed)) % 8;
      p = $unsigned($random(seed)) % 3;
      dty = (c == 0) ? 0 : (c == 1) ? per + 1 : 1 + $unsigned($random(seed)) % per;
      pwm16_case(per, dty, p);
    end
    // Subsystem 1 as two 8-bit lanes
    wr(8'h20, 32'h0000_0001);
    wr(8'h24, 32'h0000_0001);
    wr(8'h2C, 32'h0000_0503);
    wr(8'h30, 32'h0000_0204);
    wr(8'h28, 32'h0000_0000);
    wr(8'h20, 32'h0000_000D);
    repeat (48) @(posedge i_clk);
    measure(2, 48, h0);
    `CHK(h0, model_hi(3, 4, 1, 6))
    measure(3, 48, h1);
    `CHK(h1, model_hi(5, 2, 1, 4))
    // Clock enable low freezes the lane 1 waveform
    @(posedge i_clk);
    ce <= 0;
    measure(3, 24, h1);
    @(posedge i_clk);
    ce <= 1;
    `CHK(h1 % 24, 0)
    wr(8'h2C, 32'h0000_0604);
    apb(0, 8'h2C, 0, rd, er);
    `CHK(rd, 32'h0000_0604)
    // New lane 0 period takes effect at the next match
    repeat (30) @(posedge i_clk);
    measure(2, 40, h0);
    `CHK(h0, model_hi(4, 4, 1, 4))
    // Low power freezes subsystem 0 and refuses counter writes
    wr(8'h00, 32'h0000_0000);
    apb(0, 8'h08, 0, rd, er);
    h0 = rd;
    wr(8'h08, 32'h0000_0055);
    repeat (10) @(posedge i_clk);
    apb(0, 8'h08, 0, rd, er);
    `CHK(rd, 32'(h0))
    apb(0, 8'h68, 0, rd, er);
    `CHK(rd, 32'h0000_0000)
    // Subsystem 2 captures rising on pin 4, falling on pin 5
    w = 4 + $unsigned($random(seed)) % 37;
    wr(8'h40, 32'h0000_0003);
    wr(8'h44, 32'h0000_0000);
    wr(8'h40, 32'h0000_0097);
    `CHK(pin_oe[5:4], 2'b00)
    mmtu_pin_model_i.pulse(8'h30, w);
    repeat (6) @(posedge i_clk);
    apb(0, 8'h4C, 0, rd, er);
    h0 = rd;
    apb(0, 8'h50, 0, rd, er);
    `CHK(rd[15:0] - h0[15:0], 16'(w))
    // Pending, enable and request of subsystem 2
    apb(0, 8'h80, 0, rd, er);
    `CHK(rd[9:8], 2'b11)
    // Request settles at the edge that takes the write
    wr(8'h84, 32'h0000_0100);
    @(posedge i_clk);
    `CHK(irq, 4'b0100)
    wr(8'h80, 32'h0000_0100);
    @(posedge i_clk);
    `CHK(irq, 4'b0000)
    apb(0, 8'h80, 0, rd, er);
    `CHK(rd[9:8], 2'b10)
    // Capture with counter reset on channel 0
    wr(8'h40, 32'h0000_0197);
    mmtu_pin_model_i.pulse(8'h10, 2);
    mmtu_pin_model_i.pulse(8'h10, 2);
    repeat (6) @(posedge i_clk);
    apb(0, 8'h4C, 0, rd, er);
    `CHK(rd[15:0] <= 16'd8, 1'b1)
    `CHK(irq, 4'b0100)
    end_of_test();
  end
  // Watchdog on the whole run
  initial begin
    #1_000_000;
    n_errors++;
    end_of_test();
  end
endmodule
